// ---- prorc_operator.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operator panel: reset button, reset terminal and keypad, all pulled up when idle
module prorc_operator
  import prorc_pkg::*;
(
  input wire logic pclk,
  input wire logic start,
  input wire logic [1:0] which,
  input wire logic [7:0] hold,
  output logic reset_button_n,
  output logic reset_terminal_n,
  output logic key_enter_n,
  output logic key_one_n,
  output logic key_two_n,
  output logic busy
);
  logic [7:0] left_reg;
  logic [1:0] which_reg;

  // Press length counter, loaded on request
  always @(posedge pclk)
  begin
    if (start)
    begin
      left_reg <= hold;
      which_reg <= which;
    end
    else if (left_reg != 8'h00)
      left_reg <= left_reg - 8'h01;
  end

  // Released contacts return to the pull-up level
  initial left_reg = 8'h00;
  assign busy = (left_reg != 8'h00);
  assign reset_button_n = !(busy && which_reg == 2'h0);
  assign reset_terminal_n = !(busy && which_reg == 2'h1);
  assign key_enter_n = !(busy && which_reg[1]);
  assign key_one_n = !(busy && which_reg == 2'h2);
  assign key_two_n = !(busy && which_reg == 2'h3);
endmodule : prorc_operator
`default_nettype wire

// ---- prorc_pkg.sv ----
`default_nettype none
package prorc_pkg;
  // Time base
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_PERIOD_NS = 10000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Data widths and limits
  localparam int unsigned CNT_W = 20;
  localparam int unsigned TIME_W = 16;
  localparam logic [15:0] TIME_MIN = 16'h0001;
  localparam logic [15:0] TIME_MAX = 16'hea5f;
  localparam logic [19:0] PRESET_MAX = 20'hf423f;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIME1 = 8'h04;
  localparam logic [7:0] ADDR_TIME2 = 8'h08;
  localparam logic [7:0] ADDR_BTIME = 8'h0c;
  localparam logic [7:0] ADDR_PRE1 = 8'h10;
  localparam logic [7:0] ADDR_PRE2 = 8'h14;
  localparam logic [7:0] ADDR_BPRE = 8'h18;
  localparam logic [7:0] ADDR_CMD = 8'h1c;
  localparam logic [7:0] ADDR_PCNT = 8'h20;
  localparam logic [7:0] ADDR_BCNT = 8'h24;
  localparam logic [7:0] ADDR_TCNT = 8'h28;
  localparam logic [7:0] ADDR_STAT = 8'h2c;
  // Second output termination modes
  typedef enum logic [2:0] {
    TERM_OUT1_START = 3'h1,
    TERM_OUT1_END = 3'h2,
    TERM_MR_START = 3'h3,
    TERM_MR_END = 3'h4,
    TERM_TIMED = 3'h5
  } prorc_term_type;
  // Control register layout
  typedef struct packed {
    logic [2:0] bat_mode;
    logic track;
    logic [2:0] proc_mode;
    logic momentary;
    logic [2:0] act_mode;
    logic o2_rev;
    prorc_term_type o2_term;
  } prorc_ctrl_type;
  localparam int unsigned CTRL_W = 15;
  // Values after reset
  localparam logic [14:0] CTRL_RST = 15'h1113;
  localparam logic [15:0] TIME_RST = 16'h0064;
  localparam logic [19:0] PRE1_RST = 20'h00384;
  localparam logic [19:0] PRE2_RST = 20'h003e8;
  localparam logic [19:0] BPRE_RST = 20'h0000a;
endpackage : prorc_pkg
`default_nettype wire

// ---- prorc_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module preset_output_reset_control_tb_top
  import prorc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic count_pulse = 1'b0;
  logic count_down = 1'b0;
  logic lock_n = 1'b1;
  logic op_start = 1'b0;
  logic [1:0] op_which = 2'h0;
  logic [7:0] op_hold = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, out1, out2, bout, op_busy, btn_n, term_n, ent_n, one_n, two_n;
  logic [32:0] exp_q[$];
  logic [31:0] seed = 32'h00015839;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;

  // Clock at 20 MHz
  always #25 pclk = ~pclk;

  prorc_top #(.TICK_DIV(4)) u_prorc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_pulse(count_pulse), .count_down(count_down), .reset_button_n(btn_n), .reset_terminal_n(term_n),
    .key_enter_n(ent_n), .key_one_n(one_n), .key_two_n(two_n), .program_lockout_input_n(lock_n),
    .first_preset_output(out1), .second_preset_output(out2), .batch_output(bout));

  prorc_operator u_prorc_operator (.pclk(pclk), .start(op_start), .which(op_which), .hold(op_hold),
    .reset_button_n(btn_n), .reset_terminal_n(term_n), .key_enter_n(ent_n), .key_one_n(one_n),
    .key_two_n(two_n), .busy(op_busy));

  // Verdict and end of run
  task automatic close_out;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // Comparisons of register answers and of output pins
  task automatic chk_reg(input logic [32:0] e, input logic [32:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_pin

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 50)
    begin
      err_count++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({1'b0, e});
    apb(1'b0, a, 32'h00000000);
  endtask : rd

  // Operator presses and count steps
  task automatic press_start(input logic [1:0] w, input logic [7:0] h);
    op_which <= w;
    op_hold <= h;
    op_start <= 1'b1;
    @(posedge pclk);
    op_start <= 1'b0;
    @(posedge pclk);
  endtask : press_start
  task automatic wait_free;
    int n;
    n = 0;
    while (op_busy === 1'b1 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 300)
    begin
      err_count++;
      close_out();
    end
    repeat (6) @(posedge pclk);
  endtask : wait_free
  task automatic press(input logic [1:0] w);
    press_start(w, 8'h04);
    wait_free();
  endtask : press
  task automatic pulse(input int n);
    repeat (n)
    begin
      count_pulse <= 1'b1;
      @(posedge pclk);
      count_pulse <= 1'b0;
      @(posedge pclk);
    end
  endtask : pulse

  // Read answers are paired with the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk_reg(exp_q.pop_front(), {pslverr, prdata});

  // Run limit
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      close_out();
    end
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_CTRL, 32'h00001113);
    rd(ADDR_TIME2, 32'h00000064);
    rd(ADDR_PRE2, 32'h000003e8);
    rd(ADDR_BPRE, 32'h0000000a);
    exp_q.push_back({1'b1, 32'h00000000});
    apb(1'b0, 8'h30, 32'h00000000);
    wr(ADDR_TIME1, 32'h00000000);
    rd(ADDR_TIME1, 32'h00000064);
    rd(ADDR_STAT, 32'h00000008);
    wr(ADDR_TIME1, 32'h0000ea60);
    wr(ADDR_TIME1, 32'h0000ea5f);
    rd(ADDR_TIME1, 32'h0000ea5f);
    repeat (3)
    begin
      seed = lfsr(seed);
      wr(ADDR_PRE1, {13'h0000, seed[18:0]});
      rd(ADDR_PRE1, {13'h0000, seed[18:0]});
    end
    wr(ADDR_PRE1, 32'h00000064);
    wr(ADDR_PRE2, 32'h00000005);
    pulse(5);
    chk_pin(1'b1, out2);
    pulse(2);
    chk_pin(1'b1, out2);
    press(2'h0);
    chk_pin(1'b0, out2);
    rd(ADDR_PCNT, 32'h00000000);
    wr(ADDR_CTRL, 32'h00001213);
    press(2'h1);
    rd(ADDR_PCNT, 32'h00000005);
    count_down <= 1'b1;
    pulse(5);
    chk_pin(1'b1, out2);
    count_down <= 1'b0;
    wr(ADDR_CTRL, 32'h00001223);
    pulse(1);
    press(2'h0);
    rd(ADDR_PCNT, 32'h00000001);
    wr(ADDR_CTRL, 32'h00001113);
    press_start(2'h0, 8'h28);
    repeat (8) @(posedge pclk);
    pulse(3);
    rd(ADDR_STAT, 32'h00000010);
    wait_free();
    rd(ADDR_PCNT, 32'h00000000);
    wr(ADDR_CTRL, 32'h00001193);
    press_start(2'h1, 8'h28);
    repeat (8) @(posedge pclk);
    pulse(3);
    rd(ADDR_PCNT, 32'h00000003);
    wait_free();
    wr(ADDR_CTRL, 32'h0000111b);
    repeat (3) @(posedge pclk);
    chk_pin(1'b1, out2);
    pulse(2);
    chk_pin(1'b0, out2);
    press(2'h2);
    chk_pin(1'b1, out2);
    wr(ADDR_CTRL, 32'h00001115);
    wr(ADDR_TIME2, 32'h00000002);
    pulse(5);
    chk_pin(1'b1, out2);
    repeat (30) @(posedge pclk);
    chk_pin(1'b0, out2);
    wr(ADDR_TIME2, 32'h0000ea5f);
    press(2'h0);
    pulse(5);
    press(2'h3);
    chk_pin(1'b1, out2);
    press(2'h0);
    chk_pin(1'b0, out2);
    wr(ADDR_CTRL, 32'h00001315);
    wr(ADDR_TIME2, 32'h00000002);
    pulse(5);
    repeat (30) @(posedge pclk);
    rd(ADDR_PCNT, 32'h00000000);
    wr(ADDR_CTRL, 32'h00001915);
    wr(ADDR_PRE1, 32'h00000003);
    wr(ADDR_PRE2, 32'h00000008);
    rd(ADDR_PRE1, 32'h00000006);
    lock_n <= 1'b0;
    repeat (4) @(posedge pclk);
    wr(ADDR_PRE1, 32'h00000010);
    rd(ADDR_PRE1, 32'h00000006);
    lock_n <= 1'b1;
    wr(ADDR_CTRL, 32'h00001114);
    pulse(8);
    chk_pin(1'b1, out1);
    press_start(2'h0, 8'h14);
    repeat (8) @(posedge pclk);
    chk_pin(1'b1, out2);
    wait_free();
    chk_pin(1'b0, out2);
    chk_pin(1'b0, out1);
    wr(ADDR_PRE1, 32'h0000000a);
    wr(ADDR_CTRL, 32'h00001111);
    pulse(8);
    chk_pin(1'b1, out2);
    pulse(2);
    chk_pin(1'b0, out2);
    // Batch output: one output-two start reaches a batch preset of one
    press(2'h3);
    wr(ADDR_BPRE, 32'h00000001);
    wr(ADDR_BTIME, 32'h00000002);
    press(2'h0);
    pulse(8);
    chk_pin(1'b1, bout);
    rd(ADDR_BCNT, 32'h00000001);
    repeat (12) @(posedge pclk);
    chk_pin(1'b0, bout);
    close_out();
  end
endmodule : preset_output_reset_control_tb_top
`default_nettype wire

// ---- prorc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
//Behaviour
//RULE1 - Timed output one: 0.01 to 599.99 s
//RULE2 - Process manual reset cuts timed output one
//RULE3 - Zero duration refused, old value kept
//RULE4 - Output two fires at preset two or zero
//RULE5 - Process manual reset clears output two
//RULE6 - Reverse phase complements output two
//RULE7 - Mode 1 ends at output one start
//RULE8 - Mode 2 ends at output one end
//RULE9 - Mode 3 latched until reset start
//RULE10 - Mode 4 latched until reset release
//RULE11 - Mode 5 ends when timed duration expires
//RULE12 - Timed output two range, cut by reset
//RULE13 - Actuation selects process, batch, total
//RULE14 - Maintained reset holds; process hold stops counting
//RULE15 - Momentary reset acts once, counting resumes
//RULE16 - Process manual reset loads zero or preset
//RULE17 - Modes 3,4 reload after timed output two
//RULE18 - Modes 5,6 reload at timed start
//RULE19 - Tracking shifts preset one with two
//RULE20 - Tracking plus lockout rejects preset one
//RULE21 - Batch manual reset loads zero or preset
//RULE22 - Batch auto reload at timed end/start
//RULE23 - Output one fires at preset one upward
//RULE24 - Timers count down on 10 ms tick
//RULE25 - Synchronous; manual reset beats activation
module prorc_top
  import prorc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_pulse,
  input wire logic count_down,
  input wire logic reset_button_n,
  input wire logic reset_terminal_n,
  input wire logic key_enter_n,
  input wire logic key_one_n,
  input wire logic key_two_n,
  input wire logic program_lockout_input_n,
  output logic first_preset_output,
  output logic second_preset_output,
  output logic batch_output
);
  logic [5:0] sync1_reg, sync2_reg, prev_reg;
  logic [31:0] tick_reg, tick_next;
  prorc_ctrl_type ctrl_reg, ctrl_next;
  logic [15:0] len1_reg, len1_next, len2_reg, len2_next, lenb_reg, lenb_next;
  logic [15:0] t1_reg, t1_next, t2_reg, t2_next, tb_reg, tb_next;
  logic [19:0] pre1_reg, pre1_next, pre2_reg, pre2_next, bpre_reg, bpre_next;
  logic [19:0] pcnt_reg, pcnt_next, bcnt_reg, bcnt_next, tcnt_reg, tcnt_next;
  logic o1_reg, o1_next, o2_reg, o2_next, ob_reg, ob_next, entry_reg, entry_next;
  logic o2_out_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic tick, acc, wr, rst_lvl, rst_prev, k1, k1_prev, k2, k2_prev, lockout;
  logic proc_sel, bat_sel, tot_sel, mr_start, mr_end, hold, inhibit, step;
  logic proc_mr, proc_mr_start, proc_mr_end, bat_mr, tot_mr, ser_p, ser_b;
  logic [19:0] p_val, b_val, load_val;
  logic o1_hit, o1_start, o1_end, o2_hit, o2_start, t1_exp, t2_exp, tb_exp;
  logic b_down, b_hit, b_step, o2_clr, len_ok;

  // Pin synchronisers; the second stage and its one-cycle delayed copy are read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      prev_reg <= 6'h00;
    end
    else
    begin
      sync1_reg <= {~program_lockout_input_n, ~key_two_n, ~key_one_n,
                    ~key_enter_n, ~reset_terminal_n, ~reset_button_n};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Decode of operator reset sources
  always_comb
  begin
    rst_lvl = sync2_reg[0] | sync2_reg[1];
    rst_prev = prev_reg[0] | prev_reg[1];
    k1 = sync2_reg[2] & sync2_reg[3];
    k1_prev = prev_reg[2] & prev_reg[3];
    k2 = sync2_reg[2] & sync2_reg[4];
    k2_prev = prev_reg[2] & prev_reg[4];
    lockout = sync2_reg[5];
    acc = psel & penable & pready;
    wr = acc & pwrite;
    ser_p = wr & (paddr == ADDR_CMD) & pwdata[0];
    ser_b = wr & (paddr == ADDR_CMD) & pwdata[1];
    proc_sel = (ctrl_reg.act_mode == 3'h1) || (ctrl_reg.act_mode == 3'h3)
               || (ctrl_reg.act_mode == 3'h4); // RULE13
    bat_sel = (ctrl_reg.act_mode >= 3'h2) && (ctrl_reg.act_mode <= 3'h4); // RULE13
    tot_sel = ctrl_reg.act_mode == 3'h4; // RULE13
    mr_start = rst_lvl & ~rst_prev;
    mr_end = ~rst_lvl & rst_prev;
    hold = rst_lvl & ~ctrl_reg.momentary; // RULE14
    inhibit = hold & proc_sel; // RULE14
    step = count_pulse & ~inhibit; // RULE14
    // One edge in momentary action, the level in maintained action
    proc_mr = (proc_sel & (ctrl_reg.momentary ? mr_start : rst_lvl))
              | (k1 & ~k1_prev) | ser_p; // RULE15 RULE16
    proc_mr_start = (proc_sel & mr_start) | (k1 & ~k1_prev) | ser_p;
    proc_mr_end = (proc_sel & mr_end) | (k1_prev & ~k1) | ser_p;
    bat_mr = (bat_sel & (ctrl_reg.momentary ? mr_start : rst_lvl))
             | (k2 & ~k2_prev) | ser_b; // RULE15 RULE21
    tot_mr = tot_sel & (ctrl_reg.momentary ? mr_start : rst_lvl); // RULE13
  end

  // Hundredth-second tick and output events
  always_comb
  begin
    tick = tick_reg == 32'(TICK_DIV - 1); // RULE24
    tick_next = tick ? 32'h0 : tick_reg + 32'h1;
    p_val = count_down ? pcnt_reg - 20'h1 : pcnt_reg + 20'h1;
    load_val = ctrl_reg.proc_mode[0] ? 20'h0 : pre2_reg; // RULE16
    o1_hit = step & ~count_down & (p_val == pre1_reg); // RULE23
    o1_start = o1_hit & ~proc_mr & ~o1_reg; // RULE25
    t1_exp = o1_reg & tick & (t1_reg == 16'h1);
    o2_hit = step & ((p_val == pre2_reg) | (p_val == 20'h0)); // RULE4
    o2_start = o2_hit & ~proc_mr; // RULE25
    t2_exp = tick & (t2_reg == 16'h1);
    b_down = ~ctrl_reg.bat_mode[0];
    b_val = b_down ? bcnt_reg - 20'h1 : bcnt_reg + 20'h1;
    b_step = o2_start & ~o2_reg;
    b_hit = b_step & (b_down ? (b_val == 20'h0) : (b_val == bpre_reg));
    tb_exp = tick & (tb_reg == 16'h1);
    o2_clr = (ctrl_reg.o2_term == TERM_MR_END) ? proc_mr_end : proc_mr; // RULE5 RULE10
  end

  // Output state, timers and counters
  always_comb
  begin
    o1_next = o1_reg;
    t1_next = t1_reg;
    if (proc_mr)
    begin
      o1_next = 1'b0; // RULE2
      t1_next = 16'h0; // RULE2
    end
    else if (o1_start)
    begin
      o1_next = 1'b1;
      t1_next = len1_reg; // RULE1 RULE24
    end
    else if (t1_exp)
      o1_next = 1'b0;
    else if (tick && t1_reg != 16'h0)
      t1_next = t1_reg - 16'h1; // RULE24
    o1_end = o1_reg & ~o1_next;
    o2_next = o2_reg;
    if (o2_clr)
      o2_next = 1'b0; // RULE5 RULE9
    else if (o2_start)
      o2_next = 1'b1; // RULE4
    else
    begin
      unique case (ctrl_reg.o2_term)
        TERM_OUT1_START: if (o1_start) o2_next = 1'b0; // RULE7
        TERM_OUT1_END: if (o1_end) o2_next = 1'b0; // RULE8
        TERM_MR_START: o2_next = o2_reg; // RULE9
        TERM_MR_END: o2_next = o2_reg; // RULE10
        TERM_TIMED: if (t2_exp) o2_next = 1'b0; // RULE11
        default: o2_next = o2_reg;
      endcase
    end
    o2_out_next = o2_next ^ ctrl_reg.o2_rev; // RULE6
    t2_next = t2_reg;
    if (proc_mr)
      t2_next = 16'h0; // RULE12
    else if (o2_start)
      t2_next = len2_reg; // RULE12 RULE24
    else if (tick && t2_reg != 16'h0)
      t2_next = t2_reg - 16'h1; // RULE24
    // Process counter with manual and automatic reloads
    pcnt_next = pcnt_reg;
    if (proc_mr)
      pcnt_next = load_val; // RULE16 RULE25
    else if (ctrl_reg.proc_mode == 3'h5 && o2_hit && p_val == pre2_reg)
      pcnt_next = 20'h0; // RULE18
    else if (ctrl_reg.proc_mode == 3'h6 && o2_hit && p_val == 20'h0)
      pcnt_next = pre2_reg; // RULE18
    else if ((ctrl_reg.proc_mode == 3'h3 || ctrl_reg.proc_mode == 3'h4) && t2_exp)
      pcnt_next = load_val; // RULE17
    else if (step)
      pcnt_next = p_val;
    // Batch counter and its timed output
    bcnt_next = bcnt_reg;
    if (bat_mr)
      bcnt_next = ctrl_reg.bat_mode[0] ? 20'h0 : bpre_reg; // RULE21
    else if (ctrl_reg.bat_mode == 3'h5 && b_hit)
      bcnt_next = 20'h0; // RULE22
    else if (ctrl_reg.bat_mode == 3'h6 && b_hit)
      bcnt_next = bpre_reg; // RULE22
    else if ((ctrl_reg.bat_mode == 3'h3 || ctrl_reg.bat_mode == 3'h4) && tb_exp && ob_reg)
      bcnt_next = ctrl_reg.bat_mode[0] ? 20'h0 : bpre_reg; // RULE22
    else if (b_step && !inhibit)
      bcnt_next = b_val;
    ob_next = ob_reg;
    tb_next = tb_reg;
    if (bat_mr)
    begin
      ob_next = 1'b0;
      tb_next = 16'h0;
    end
    else if (b_hit)
    begin
      ob_next = 1'b1;
      tb_next = lenb_reg; // RULE24
    end
    else if (tb_exp)
    begin
      ob_next = 1'b0;
      tb_next = 16'h0;
    end
    else if (tick && tb_reg != 16'h0)
      tb_next = tb_reg - 16'h1; // RULE24
    tcnt_next = tot_mr ? 20'h0 : (step ? tcnt_reg + 20'h1 : tcnt_reg); // RULE13 RULE14
  end

  // Register writes and read answer
  always_comb
  begin
    ctrl_next = ctrl_reg;
    len1_next = len1_reg;
    len2_next = len2_reg;
    lenb_next = lenb_reg;
    pre1_next = pre1_reg;
    pre2_next = pre2_reg;
    bpre_next = bpre_reg;
    entry_next = entry_reg;
    len_ok = (pwdata[15:0] >= TIME_MIN) && (pwdata[15:0] <= TIME_MAX); // RULE1 RULE3
    if (wr)
    begin
      unique case (paddr)
        ADDR_CTRL: ctrl_next = prorc_ctrl_type'(pwdata[CTRL_W-1:0]);
        ADDR_TIME1: if (len_ok) len1_next = pwdata[15:0]; // RULE3
        ADDR_TIME2: if (len_ok) len2_next = pwdata[15:0]; // RULE3 RULE12
        ADDR_BTIME: if (len_ok) lenb_next = pwdata[15:0]; // RULE3
        ADDR_PRE1: if (!(ctrl_reg.track && lockout) && pwdata[19:0] <= PRESET_MAX)
            pre1_next = pwdata[19:0]; // RULE20
        ADDR_PRE2:
          if (pwdata[19:0] <= PRESET_MAX)
          begin
            pre2_next = pwdata[19:0];
            if (ctrl_reg.track)
              pre1_next = pre1_reg + pwdata[19:0] - pre2_reg; // RULE19
          end
        ADDR_BPRE: if (pwdata[19:0] <= PRESET_MAX) bpre_next = pwdata[19:0];
        default: ctrl_next = ctrl_reg;
      endcase
      if (paddr == ADDR_TIME1 || paddr == ADDR_TIME2 || paddr == ADDR_BTIME)
        entry_next = ~len_ok; // RULE3
    end
    pready_next = psel & penable & ~pready;
    prdata_next = prdata;
    pslverr_next = 1'b0;
    if (psel && penable && !pready)
    begin
      unique case (paddr)
        ADDR_CTRL: prdata_next = {17'h0, ctrl_reg};
        ADDR_TIME1: prdata_next = {16'h0, len1_reg};
        ADDR_TIME2: prdata_next = {16'h0, len2_reg};
        ADDR_BTIME: prdata_next = {16'h0, lenb_reg};
        ADDR_PRE1: prdata_next = {12'h0, pre1_reg};
        ADDR_PRE2: prdata_next = {12'h0, pre2_reg};
        ADDR_BPRE: prdata_next = {12'h0, bpre_reg};
        ADDR_CMD: prdata_next = 32'h0;
        ADDR_PCNT: prdata_next = {12'h0, pcnt_reg};
        ADDR_BCNT: prdata_next = {12'h0, bcnt_reg};
        ADDR_TCNT: prdata_next = {12'h0, tcnt_reg};
        ADDR_STAT: prdata_next = {27'h0, inhibit, entry_reg, ob_reg, o2_reg, o1_reg};
        default:
        begin
          prdata_next = 32'h0;
          pslverr_next = 1'b1;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_reg <= 32'h0;
      ctrl_reg <= prorc_ctrl_type'(CTRL_RST);
      len1_reg <= TIME_RST;
      len2_reg <= TIME_RST;
      lenb_reg <= TIME_RST;
      t1_reg <= 16'h0;
      t2_reg <= 16'h0;
      tb_reg <= 16'h0;
      pre1_reg <= PRE1_RST;
      pre2_reg <= PRE2_RST;
      bpre_reg <= BPRE_RST;
      pcnt_reg <= 20'h0;
      bcnt_reg <= 20'h0;
      tcnt_reg <= 20'h0;
      o1_reg <= 1'b0;
      o2_reg <= 1'b0;
      ob_reg <= 1'b0;
      entry_reg <= 1'b0;
      second_preset_output <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      tick_reg <= tick_next;
      ctrl_reg <= ctrl_next;
      len1_reg <= len1_next;
      len2_reg <= len2_next;
      lenb_reg <= lenb_next;
      t1_reg <= t1_next;
      t2_reg <= t2_next;
      tb_reg <= tb_next;
      pre1_reg <= pre1_next;
      pre2_reg <= pre2_next;
      bpre_reg <= bpre_next;
      pcnt_reg <= pcnt_next;
      bcnt_reg <= bcnt_next;
      tcnt_reg <= tcnt_next;
      o1_reg <= o1_next;
      o2_reg <= o2_next;
      ob_reg <= ob_next;
      entry_reg <= entry_next;
      second_preset_output <= o2_out_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  assign first_preset_output = o1_reg;
  assign batch_output = ob_reg;

  // Checks on reset, duration entry, output two phase, termination, preset and timer behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [19:0] pre_gap;
  assign pre_gap = pre2_reg - pre1_reg;

  property p_o1_cut;
    proc_mr |=> !o1_reg && t1_reg == 16'h0;
  endproperty
  a_o1_cut: assert property (p_o1_cut) else $error("output one not cut by reset"); // RULE2
  property p_zero_len;
    wr && paddr == ADDR_TIME1 && pwdata[15:0] == 16'h0 |=> $stable(len1_reg) && entry_reg;
  endproperty
  a_zero_len: assert property (p_zero_len) else $error("zero duration accepted"); // RULE3
  property p_o2_clr;
    proc_mr && ctrl_reg.o2_term != TERM_MR_END |=> !o2_reg;
  endproperty
  a_o2_clr: assert property (p_o2_clr) else $error("output two survived reset"); // RULE5
  property p_phase;
    ##1 second_preset_output == (o2_reg ^ $past(ctrl_reg.o2_rev));
  endproperty
  a_phase: assert property (p_phase) else $error("output two phase wrong"); // RULE6
  property p_latch;
    ctrl_reg.o2_term == TERM_MR_START && o2_reg && !proc_mr ##1 !proc_mr |-> o2_reg;
  endproperty
  a_latch: assert property (p_latch) else $error("latched output two dropped"); // RULE9
  property p_timed;
    ctrl_reg.o2_term == TERM_TIMED && o2_reg && t2_exp && !o2_start |=> !o2_reg;
  endproperty
  a_timed: assert property (p_timed) else $error("timed output two not ended"); // RULE11
  property p_hold;
    inhibit |=> pcnt_reg == $past(load_val);
  endproperty
  a_hold: assert property (p_hold) else $error("held counter moved"); // RULE14
  property p_track;
    wr && paddr == ADDR_PRE2 && ctrl_reg.track && pwdata[19:0] <= PRESET_MAX |=> $stable(pre_gap);
  endproperty
  a_track: assert property (p_track) else $error("preset offset lost"); // RULE19
  property p_lock;
    wr && paddr == ADDR_PRE1 && ctrl_reg.track && lockout |=> $stable(pre1_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked preset one changed"); // RULE20
  property p_t1_load;
    o1_start |=> o1_reg && t1_reg == $past(len1_reg);
  endproperty
  a_t1_load: assert property (p_t1_load) else $error("timer one not loaded"); // RULE24
  property p_prio;
    proc_mr && o2_hit |=> !o1_reg && t2_reg == 16'h0;
  endproperty
  a_prio: assert property (p_prio) else $error("activation beat manual reset"); // RULE25

  property p_cv_o2_timed;
    o2_start ##1 o2_reg [*2];
  endproperty
  c_o2_timed: cover property (p_cv_o2_timed);
  property p_cv_hold;
    inhibit [*3];
  endproperty
  c_hold: cover property (p_cv_hold);
  property p_cv_batch;
    b_hit ##1 ob_reg;
  endproperty
  c_batch: cover property (p_cv_batch);
endmodule : prorc_top
`default_nettype wire
